/* dmach_channel.sv */
// dma channel, normal transfer mode, with axi4-lite register slave
//
// Summary of operation
// - The trigger is the interrupt request whose vector number sits in the source selector.
// - A fixed source address mode leaves the source address unchanged after each transfer.
// - An increment destination mode advances the destination by the unit size per transfer.
// - Transfers start only on requests from the selected peripheral when that source is chosen.
// - Normal mode moves one unit per request and counts down, with no repeat or reload.
// - The lowest size encoding moves one byte and steps addresses by one byte.
// - With the flag-clear select bit at zero, the peripheral flag is cleared at transfer start.
// - After the last counted transfer the end interrupt is raised if it is enabled.
`timescale 1ns/1ps
module dmach_channel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [dmach_pkg::NUM_VEC-1:0] irq_req,
  output logic irq_clear_valid,
  output logic [dmach_pkg::VEC_W-1:0] irq_clear_vec,
  output dmach_pkg::dmach_mem_s mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic channel0_end_interrupt
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] activation_source_select_reg;
  logic [1:0] source_addr_mode_reg;
  logic [1:0] destination_addr_mode_reg;
  logic [1:0] request_source_select_reg;
  logic [1:0] transfer_mode_select_reg;
  logic [1:0] transfer_size_select_reg;
  logic interrupt_flag_clear_select_reg;
  logic channel_transfer_enable_reg;
  logic transfer_end_irq_enable_reg;
  logic controller_activation_enable_reg;
  logic [31:0] source_address_reg;
  logic [31:0] destination_address_reg;
  logic [dmach_pkg::CNT_W-1:0] transfer_count_reg;
  logic end_flag_reg;
  logic pend_reg;
  logic sel_prev_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0] wr_strb_reg;
  logic sel_req;
  logic start;
  logic eng_done;
  logic eng_busy;
  logic wr_fire;
  logic last;
  logic [31:0] rd_next;
  logic rd_hit;
  logic wr_hit;
  logic [31:0] wr_bits;
  logic [31:0] cnt_merged;

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  assign wr_fire = !awready && !wready && !bvalid;

  always_comb begin
    case (wr_addr_reg)
      dmach_pkg::OFS_ACT_SRC, dmach_pkg::OFS_ADDR_MODE, dmach_pkg::OFS_XFER_MODE,
      dmach_pkg::OFS_CLR_SEL, dmach_pkg::OFS_CH_CTRL, dmach_pkg::OFS_IRQ_EN,
      dmach_pkg::OFS_CTRL_START, dmach_pkg::OFS_SRC_ADDR, dmach_pkg::OFS_DST_ADDR,
      dmach_pkg::OFS_COUNT, dmach_pkg::OFS_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= dmach_pkg::RESP_OKAY;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      wr_strb_reg <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        wr_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wr_data_reg <= wdata;
        wr_strb_reg <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? dmach_pkg::RESP_OKAY : dmach_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  assign wr_bits = dmach_pkg::merge('0, wr_data_reg, wr_strb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      activation_source_select_reg <= '0;
      source_addr_mode_reg <= dmach_pkg::AM_FIXED;
      destination_addr_mode_reg <= dmach_pkg::AM_FIXED;
      request_source_select_reg <= '0;
      transfer_mode_select_reg <= dmach_pkg::MD_NORMAL;
      transfer_size_select_reg <= dmach_pkg::SZ_BYTE;
      interrupt_flag_clear_select_reg <= 1'b0;
      transfer_end_irq_enable_reg <= 1'b0;
      controller_activation_enable_reg <= 1'b0;
    end else if (wr_fire && wr_strb_reg[0]) begin
      case (wr_addr_reg)
        dmach_pkg::OFS_ACT_SRC: activation_source_select_reg <= wr_bits[7:0];
        dmach_pkg::OFS_ADDR_MODE: begin
          source_addr_mode_reg <= wr_bits[dmach_pkg::AM_SRC_LSB +: 2];
          destination_addr_mode_reg <= wr_bits[dmach_pkg::AM_DST_LSB +: 2];
        end
        dmach_pkg::OFS_XFER_MODE: begin
          request_source_select_reg <= wr_bits[dmach_pkg::TM_RS_LSB +: 2];
          transfer_mode_select_reg <= wr_bits[dmach_pkg::TM_MD_LSB +: 2];
          transfer_size_select_reg <= wr_bits[dmach_pkg::TM_SZ_LSB +: 2];
        end
        dmach_pkg::OFS_CLR_SEL: interrupt_flag_clear_select_reg <= wr_bits[0];
        dmach_pkg::OFS_IRQ_EN: transfer_end_irq_enable_reg <= wr_bits[0];
        dmach_pkg::OFS_CTRL_START: controller_activation_enable_reg <= wr_bits[0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // addresses, count and channel enable
  // ----------------------------------------
  assign last = (transfer_count_reg == dmach_pkg::CNT_LAST);
  assign cnt_merged = dmach_pkg::merge(32'(transfer_count_reg), wr_data_reg, wr_strb_reg);

  // hardware updates win over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_address_reg <= '0;
      destination_address_reg <= '0;
      transfer_count_reg <= '0;
      channel_transfer_enable_reg <= 1'b0;
    end else if (eng_done) begin
      source_address_reg <= dmach_pkg::next_addr(source_address_reg, source_addr_mode_reg,
                                                 transfer_size_select_reg);
      destination_address_reg <= dmach_pkg::next_addr(destination_address_reg,
        destination_addr_mode_reg, transfer_size_select_reg);
      transfer_count_reg <= transfer_count_reg - dmach_pkg::CNT_STEP;
      if (last) begin
        channel_transfer_enable_reg <= 1'b0;
      end
    end else if (wr_fire) begin
      case (wr_addr_reg)
        dmach_pkg::OFS_SRC_ADDR:
          source_address_reg <= dmach_pkg::merge(source_address_reg, wr_data_reg, wr_strb_reg);
        dmach_pkg::OFS_DST_ADDR: destination_address_reg <=
          dmach_pkg::merge(destination_address_reg, wr_data_reg, wr_strb_reg);
        dmach_pkg::OFS_COUNT: transfer_count_reg <= cnt_merged[dmach_pkg::CNT_W-1:0];
        dmach_pkg::OFS_CH_CTRL:
          if (wr_strb_reg[0]) channel_transfer_enable_reg <= wr_data_reg[0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // request capture and start
  // ----------------------------------------
  assign sel_req = irq_req[activation_source_select_reg];

  // a request edge arriving while the pending flag is taken still sets it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_prev_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      sel_prev_reg <= sel_req;
      if (sel_req && !sel_prev_reg) begin
        pend_reg <= 1'b1;
      end else if (start) begin
        pend_reg <= 1'b0;
      end
    end
  end

  assign start = pend_reg && channel_transfer_enable_reg
    && controller_activation_enable_reg
    && request_source_select_reg == dmach_pkg::RS_PERIPH
    && transfer_mode_select_reg == dmach_pkg::MD_NORMAL
    && !eng_busy && !eng_done;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_clear_valid <= 1'b0;
      irq_clear_vec <= '0;
    end else begin
      irq_clear_valid <= start && !interrupt_flag_clear_select_reg;
      if (start) begin
        irq_clear_vec <= activation_source_select_reg;
      end
    end
  end

  dmach_engine u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start),
    .src_addr(source_address_reg),
    .dst_addr(destination_address_reg),
    .size(transfer_size_select_reg),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .mem(mem),
    .done(eng_done),
    .busy(eng_busy)
  );

  // ----------------------------------------
  // transfer end flag and interrupt
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      end_flag_reg <= 1'b0;
      channel0_end_interrupt <= 1'b0;
    end else begin
      if (eng_done && last) begin
        end_flag_reg <= 1'b1;
      end else if (wr_fire && wr_addr_reg == dmach_pkg::OFS_STATUS && wr_strb_reg[0]
                   && wr_data_reg[dmach_pkg::STS_END]) begin
        end_flag_reg <= 1'b0;
      end
      channel0_end_interrupt <= end_flag_reg && transfer_end_irq_enable_reg;
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  always_comb begin
    rd_next = '0;
    rd_hit = 1'b1;
    case (araddr)
      dmach_pkg::OFS_ACT_SRC: rd_next[7:0] = activation_source_select_reg;
      dmach_pkg::OFS_ADDR_MODE: begin
        rd_next[dmach_pkg::AM_SRC_LSB +: 2] = source_addr_mode_reg;
        rd_next[dmach_pkg::AM_DST_LSB +: 2] = destination_addr_mode_reg;
      end
      dmach_pkg::OFS_XFER_MODE: begin
        rd_next[dmach_pkg::TM_RS_LSB +: 2] = request_source_select_reg;
        rd_next[dmach_pkg::TM_MD_LSB +: 2] = transfer_mode_select_reg;
        rd_next[dmach_pkg::TM_SZ_LSB +: 2] = transfer_size_select_reg;
      end
      dmach_pkg::OFS_CLR_SEL: rd_next[0] = interrupt_flag_clear_select_reg;
      dmach_pkg::OFS_CH_CTRL: rd_next[0] = channel_transfer_enable_reg;
      dmach_pkg::OFS_IRQ_EN: rd_next[0] = transfer_end_irq_enable_reg;
      dmach_pkg::OFS_CTRL_START: rd_next[0] = controller_activation_enable_reg;
      dmach_pkg::OFS_SRC_ADDR: rd_next = source_address_reg;
      dmach_pkg::OFS_DST_ADDR: rd_next = destination_address_reg;
      dmach_pkg::OFS_COUNT: rd_next[dmach_pkg::CNT_W-1:0] = transfer_count_reg;
      dmach_pkg::OFS_STATUS: begin
        rd_next[dmach_pkg::STS_BUSY] = eng_busy;
        rd_next[dmach_pkg::STS_END] = end_flag_reg;
        rd_next[dmach_pkg::STS_PEND] = pend_reg;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= dmach_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_next;
      rresp <= rd_hit ? dmach_pkg::RESP_OKAY : dmach_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_start;
    start;
  endsequence
  sequence s_last_done;
    eng_done && last;
  endsequence

  property p_trigger_source;
    s_start |-> pend_reg && $past(sel_req) | $past(pend_reg);
  endproperty
  a_trigger_source: assert property (p_trigger_source) else $error("start without request");
  property p_src_fixed;
    eng_done && source_addr_mode_reg == dmach_pkg::AM_FIXED
      |=> $stable(source_address_reg);
  endproperty
  a_src_fixed: assert property (p_src_fixed) else $error("fixed source moved");
  property p_dst_inc_byte;
    eng_done && destination_addr_mode_reg == dmach_pkg::AM_INC
      && transfer_size_select_reg == dmach_pkg::SZ_BYTE
      |=> destination_address_reg == $past(destination_address_reg) + 32'h0000_0001;
  endproperty
  a_dst_inc_byte: assert property (p_dst_inc_byte) else $error("destination step wrong");
  property p_periph_only;
    s_start |-> request_source_select_reg == dmach_pkg::RS_PERIPH;
  endproperty
  a_periph_only: assert property (p_periph_only) else $error("start from wrong source");
  property p_one_unit;
    s_start |=> mem.req && !mem.we ##0 !start [*2];
  endproperty
  a_one_unit: assert property (p_one_unit) else $error("unit transfer not single");
  property p_flag_clear;
    (s_start and !interrupt_flag_clear_select_reg)
      |=> irq_clear_valid && irq_clear_vec == $past(activation_source_select_reg);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
  property p_end_irq;
    (s_last_done and transfer_end_irq_enable_reg) |=> end_flag_reg ##1 channel0_end_interrupt;
  endproperty
  a_end_irq: assert property (p_end_irq) else $error("end interrupt missing");
  property p_gate;
    s_start |-> channel_transfer_enable_reg && controller_activation_enable_reg;
  endproperty
  a_gate: assert property (p_gate) else $error("start while disabled");
  property p_count;
    eng_done |=> transfer_count_reg == $past(transfer_count_reg) - 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("count not decremented");
  property p_last_disable;
    s_last_done |=> !channel_transfer_enable_reg;
  endproperty
  a_last_disable: assert property (p_last_disable) else $error("enable not cleared");
endmodule

/* dmach_engine.sv */
// dma channel bus engine: one read then one write per start
`timescale 1ns/1ps
module dmach_engine (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [31:0] src_addr,
  input wire logic [31:0] dst_addr,
  input wire logic [1:0] size,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output dmach_pkg::dmach_mem_s mem,
  output logic done,
  output logic busy
);
  dmach_pkg::dmach_eng_e state_reg;
  logic [31:0] dst_hold_reg;

  assign busy = (state_reg != dmach_pkg::ENG_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= dmach_pkg::ENG_IDLE;
      mem <= '0;
      dst_hold_reg <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        dmach_pkg::ENG_IDLE: begin
          if (start) begin
            mem.req <= 1'b1;
            mem.we <= 1'b0;
            mem.addr <= src_addr;
            mem.size <= size;
            dst_hold_reg <= dst_addr;
            state_reg <= dmach_pkg::ENG_READ;
          end
        end
        dmach_pkg::ENG_READ: begin
          if (mem_ack) begin
            // the read unit goes straight back out as the write
            mem.we <= 1'b1;
            mem.addr <= dst_hold_reg;
            mem.wdata <= mem_rdata;
            state_reg <= dmach_pkg::ENG_WRITE;
          end
        end
        dmach_pkg::ENG_WRITE: begin
          if (mem_ack) begin
            mem.req <= 1'b0;
            mem.we <= 1'b0;
            done <= 1'b1;
            state_reg <= dmach_pkg::ENG_IDLE;
          end
        end
        default: begin
          mem.req <= 1'b0;
          state_reg <= dmach_pkg::ENG_IDLE;
        end
      endcase
    end
  end
endmodule

/* dmach_mem_model.sv */
// memory and receive-register model on the far side of the channel bus port
`timescale 1ns/1ps
module dmach_mem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire dmach_pkg::dmach_mem_s mem,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [7:0] ram [256];
  logic [7:0] rx_reg;
  logic [1:0] wait_reg;

  // reads return a fresh receive byte each time; idle data toggles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      wait_reg <= 2'h0;
      rx_reg <= 8'h40;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem.req && !mem_ack) begin
        if (!slow || wait_reg == 2'h3) begin
          mem_ack <= 1'b1;
          wait_reg <= 2'h0;
          if (!mem.we) begin
            mem_rdata <= {~mem_rdata[31:8], rx_reg};
            rx_reg <= rx_reg + 8'h01;
          end else begin
            ram[mem.addr[7:0]] <= mem.wdata[7:0];
          end
        end else begin
          wait_reg <= wait_reg + 2'h1;
        end
      end
    end
  end
endmodule

/* dmach_pkg.sv */
// dma channel package: register map, encodings, carrier types
package dmach_pkg;
  localparam int CNT_W = 16;
  localparam int VEC_W = 8;
  localparam int NUM_VEC = 256;
  // register byte offsets
  localparam logic [7:0] OFS_ACT_SRC = 8'h00;
  localparam logic [7:0] OFS_ADDR_MODE = 8'h04;
  localparam logic [7:0] OFS_XFER_MODE = 8'h08;
  localparam logic [7:0] OFS_CLR_SEL = 8'h0C;
  localparam logic [7:0] OFS_CH_CTRL = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] OFS_CTRL_START = 8'h18;
  localparam logic [7:0] OFS_SRC_ADDR = 8'h1C;
  localparam logic [7:0] OFS_DST_ADDR = 8'h20;
  localparam logic [7:0] OFS_COUNT = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  // field positions
  localparam int AM_SRC_LSB = 0;
  localparam int AM_DST_LSB = 2;
  localparam int TM_RS_LSB = 0;
  localparam int TM_MD_LSB = 2;
  localparam int TM_SZ_LSB = 4;
  localparam int STS_BUSY = 0;
  localparam int STS_END = 1;
  localparam int STS_PEND = 2;
  // encodings
  localparam logic [1:0] AM_FIXED = 2'h0;
  localparam logic [1:0] AM_INC = 2'h2;
  localparam logic [1:0] AM_DEC = 2'h3;
  localparam logic [1:0] RS_PERIPH = 2'h1;
  localparam logic [1:0] MD_NORMAL = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [CNT_W-1:0] CNT_LAST = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;
  localparam logic [31:0] ADDR_UNIT = 32'h0000_0001;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
  } dmach_mem_s;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_READ = 2'b01,
    ENG_WRITE = 2'b10
  } dmach_eng_e;

  // address after one transfer: step is 1, 2, 4 or 8 bytes by size
  function automatic logic [31:0] next_addr(input logic [31:0] a, input logic [1:0] mode,
                                            input logic [1:0] sz);
    logic [31:0] step;
    step = ADDR_UNIT << sz;
    case (mode)
      AM_INC: next_addr = a + step;
      AM_DEC: next_addr = a - step;
      default: next_addr = a;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = d[8*i +: 8];
      end
    end
  endfunction
endpackage

/* test_dmach_channel.sv */
// self-checking bench for the dma channel in normal transfer mode
`timescale 1ns/1ps
module test_dmach_channel;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq_clear_valid, mem_ack;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, mem_rdata, rd;
  logic [dmach_pkg::NUM_VEC-1:0] irq_req = '0;
  logic [dmach_pkg::VEC_W-1:0] irq_clear_vec;
  dmach_pkg::dmach_mem_s mem;
  logic channel0_end_interrupt;
  logic slow = 1'b0;
  int error_cnt = 0;
  int n_compared = 0;
  int clr_cnt = 0;
  int bad_cnt = 0;
  int cycles = 0;

  always #25 aclk = ~aclk;

  dmach_channel u_dmach_channel (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .irq_req, .irq_clear_valid, .irq_clear_vec, .mem, .mem_ack, .mem_rdata,
    .channel0_end_interrupt);
  dmach_mem_model u_dmach_mem_model (.aclk, .aresetn, .slow, .mem, .mem_ack, .mem_rdata);

  task automatic results();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic pulse(input int v);
    @(posedge aclk);
    irq_req[v] <= 1'b1;
    @(posedge aclk);
    irq_req[v] <= 1'b0;
  endtask

  task automatic xfer();
    do @(posedge aclk); while (mem.req !== 1'b1);
    do @(posedge aclk); while (mem.req !== 1'b0);
    repeat (3) @(posedge aclk);
  endtask

  // ----------------------------------------
  // monitor and timeout
  // ----------------------------------------
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("mismatch at %0t: run timed out", $time);
      results();
    end
    if (aresetn && irq_clear_valid) begin
      clr_cnt++;
      if (irq_clear_vec !== 8'h3E) bad_cnt++;
    end
    if (aresetn && mem.req && mem.size !== dmach_pkg::SZ_BYTE) bad_cnt++;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd_reg(8'(4 * i));
      chk(rd, 32'h0000_0000);
    end
    rd_reg(8'h2C);
    chk(32'(rsp), 32'(dmach_pkg::RESP_SLVERR));
    chk(rd, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    chk(32'(rsp), 32'(dmach_pkg::RESP_SLVERR));
    wr(dmach_pkg::OFS_CLR_SEL, 32'h0000_0000);
    wr(dmach_pkg::OFS_ACT_SRC, 32'h0000_003E);
    wr(dmach_pkg::OFS_ADDR_MODE, 32'h0000_0008);
    wr(dmach_pkg::OFS_XFER_MODE, 32'h0000_0001);
    wr(dmach_pkg::OFS_SRC_ADDR, 32'h0000_0010);
    wr(dmach_pkg::OFS_DST_ADDR, 32'h0000_0080);
    wr(dmach_pkg::OFS_COUNT, 32'h0000_0020);
    wr(dmach_pkg::OFS_IRQ_EN, 32'h0000_0001);
    wr(dmach_pkg::OFS_CH_CTRL, 32'h0000_0001);
    pulse(62);
    repeat (10) @(posedge aclk);
    chk(clr_cnt, 0);
    wr(dmach_pkg::OFS_CTRL_START, 32'h0000_0001);
    xfer();
    chk(clr_cnt, 1);
    rd_reg(dmach_pkg::OFS_COUNT);
    chk(rd, 32'h0000_001F);
    rd_reg(dmach_pkg::OFS_DST_ADDR);
    chk(rd, 32'h0000_0081);
    rd_reg(dmach_pkg::OFS_SRC_ADDR);
    chk(rd, 32'h0000_0010);
    pulse(61);
    repeat (10) @(posedge aclk);
    chk(clr_cnt, 1);
    // other request source, then a non-normal mode: request waits
    for (int m = 0; m < 2; m++) begin
      wr(dmach_pkg::OFS_XFER_MODE, (m == 1) ? 32'h0000_0005 : 32'h0000_0000);
      pulse(62);
      repeat (10) @(posedge aclk);
      chk(clr_cnt, 1 + m);
      wr(dmach_pkg::OFS_XFER_MODE, 32'h0000_0001);
      xfer();
    end
    for (int k = 0; k < 29; k++) begin
      slow <= (k < 4);
      chk(32'(channel0_end_interrupt), 32'h0000_0000);
      pulse(62);
      xfer();
    end
    chk(clr_cnt, 32);
    chk(bad_cnt, 0);
    for (int j = 0; j < 32; j++) begin
      chk(32'(u_dmach_mem_model.ram[8'h80 + j]), 32'(8'h40 + j));
    end
    rd_reg(dmach_pkg::OFS_DST_ADDR);
    chk(rd, 32'h0000_00A0);
    rd_reg(dmach_pkg::OFS_SRC_ADDR);
    chk(rd, 32'h0000_0010);
    rd_reg(dmach_pkg::OFS_COUNT);
    chk(rd, 32'h0000_0000);
    rd_reg(dmach_pkg::OFS_CH_CTRL);
    chk(rd, 32'h0000_0000);
    chk(32'(channel0_end_interrupt), 32'h0000_0001);
    pulse(62);
    repeat (10) @(posedge aclk);
    chk(clr_cnt, 32);
    wr(dmach_pkg::OFS_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk(32'(channel0_end_interrupt), 32'h0000_0000);
    wr(dmach_pkg::OFS_IRQ_EN, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk(32'(channel0_end_interrupt), 32'h0000_0001);
    wr(dmach_pkg::OFS_STATUS, 32'h0000_0002);
    repeat (2) @(posedge aclk);
    chk(32'(channel0_end_interrupt), 32'h0000_0000);
    // stale pending request starts at once: source down, word size
    wr(dmach_pkg::OFS_ADDR_MODE, 32'h0000_000B);
    wr(dmach_pkg::OFS_XFER_MODE, 32'h0000_0021);
    wr(dmach_pkg::OFS_COUNT, 32'h0000_0001);
    wr(dmach_pkg::OFS_CH_CTRL, 32'h0000_0001);
    xfer();
    chk(clr_cnt, 33);
    chk(32'(u_dmach_mem_model.ram[8'hA0]), 32'h0000_0060);
    rd_reg(dmach_pkg::OFS_SRC_ADDR);
    chk(rd, 32'h0000_000C);
    rd_reg(dmach_pkg::OFS_DST_ADDR);
    chk(rd, 32'h0000_00A4);
    rd_reg(dmach_pkg::OFS_CH_CTRL);
    chk(rd, 32'h0000_0000);
    chk(32'(channel0_end_interrupt), 32'h0000_0001);
    results();
  end
endmodule
